// File: logic/sec_top.sv
// serial eeprom command interface: link logic on sck, status and write timer on i_clk
// Overview of operation
// - only clock modes (0,0) and (1,1); host picks one of these.
// - serial input sampled on every rising sck edge while selected and pause input high.
// - serial output changes on falling sck edges while shifting data out.
// - chip select high: output high impedance; standby unless writing.
// - first eight bits after selection form the opcode.
// - only the six opcodes act; any other byte is ignored.
// - opcode 06 sets write latch; opcode 04 clears it.
// - opcode 05 returns status; opcode 01 loads status from next byte.
// - opcode 03 reads memory, 02 writes; address follows, write adds data.
// - protect pin high never blocks a write.
// - protect pin low with guard bit set refuses status writes.
// - pause input low suspends transfer keeping state; high resumes.
// - page select bit set redirects reads and writes to 256-byte id page.
// - id page can be locked read-only permanently.
// - self-timed write starts at closing select edge, ends within 5 ms.
// - busy bit is 1 during write cycle, 0 when ready.
// - write latch bit set by set opcode, cleared by clear opcode.
// - memory write carries 24-bit address then at least one byte.
// - guard bit enables protect pin; clear bit makes pin ineffective.
`timescale 1ns/1ps
module sec_top
  import sec_pkg::*;
#(
  parameter int WR_CYCLES = WC_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_sck,
  input  wire logic i_cs_n,
  input  wire logic i_si,
  input  wire logic i_wp_n,
  input  wire logic i_hold_n,
  output logic      o_so,
  output logic      o_so_oe,
  output logic      o_busy
);
  if (WR_CYCLES < 8 || WR_CYCLES >= (1 << WC_CNT_W)) begin : g_chk
    $error("WR_CYCLES must lie between 8 and the write counter range");
  end
  function automatic logic [MEM_AW-1:0] mem_addr_map(input logic id_page_select_bit, input logic [23:0] a);
    mem_addr_map = id_page_select_bit ? {1'b1, 9'h000, a[7:0]} : {1'b0, a[16:0]};
  endfunction
  function automatic logic is_known(input logic [7:0] b);
    is_known = (b == SET_WRITE_LATCH_CMD) || (b == CLEAR_WRITE_LATCH_CMD) ||
               (b == STATUS_READ_CMD) || (b == STATUS_WRITE_CMD) ||
               (b == MEM_READ_CMD) || (b == MEM_WRITE_CMD);
  endfunction
  function automatic logic in_block(input logic [1:0] bp, input logic a16, input logic a15);
    case (bp)
      BP_FULL:    in_block = 1'b1;
      BP_HALF:    in_block = a16;
      BP_QUARTER: in_block = a16 & a15;
      default:    in_block = 1'b0;
    endcase
  endfunction

  // ---------------- link domain (i_sck) ----------------
  wire link_rst_n = i_rstn & ~i_cs_n;
  sec_link_st_e state_q;
  sec_link_st_e state_d;
  logic [2:0]   bit_cnt_q;
  logic [1:0]   addr_cnt_q;
  logic [7:0]   shift_q;
  logic [23:0]  addr_q;
  logic [7:0]   op_q;
  logic         op_ok_q;
  logic         wr_any_q;
  logic         status_write_cmd_got_q;
  logic [7:0]   status_write_cmd_byte_q;
  logic [7:0]   tx_q;
  logic         so_q;
  logic         so_oe_q;
  logic [7:0]   stat_l;
  logic [7:0]   mem_rdata;
  logic [7:0]   status_w;
  wire [7:0]  byte_in   = {shift_q[6:0], i_si};
  wire        byte_end  = (bit_cnt_q == BIT_LAST) & i_hold_n;
  wire        busy_l    = stat_l[BUSY_BIT];
  wire        ipl_l     = stat_l[ID_PAGE_SELECT_BIT];
  wire        lip_l     = stat_l[ID_PAGE_LOCK_BIT];
  wire [1:0]  bp_l      = stat_l[BLOCK_HI_BIT:BLOCK_LO_BIT];
  wire        op_accept = is_known(byte_in) & (~busy_l | (byte_in == STATUS_READ_CMD));
  wire        rd_op     = (op_q == MEM_READ_CMD);
  wire        addr_last = (addr_cnt_q == ADDR_LAST);
  wire [23:0] addr_full = {addr_q[15:0], byte_in};
  wire        blk_main  = in_block(bp_l, addr_q[16], addr_q[15]);
  wire        blk_any   = ipl_l ? (lip_l | (bp_l == BP_FULL) | blk_main) : blk_main;
  wire        wr_permit = stat_l[WRITE_ENABLE_LATCH_BIT] & ~busy_l & ~blk_any;
  wire        mem_we    = byte_end & (state_q == ST_WDATA) & wr_permit;
  wire        rd_first  = (state_q == ST_ADDR) & addr_last & rd_op;
  wire        mem_re    = byte_end & (rd_first | (state_q == ST_RDATA));
  wire [MEM_AW-1:0] mem_waddr = mem_addr_map(ipl_l, addr_q);
  wire [MEM_AW-1:0] mem_raddr = mem_addr_map(ipl_l, rd_first ? addr_full : addr_q);
  wire        sending   = (state_q == ST_SRD) | (state_q == ST_RDATA);
  wire [7:0]  tx_src    = (state_q == ST_SRD) ? stat_l : mem_rdata;

  always_comb begin
    state_d = state_q;
    if (byte_end) begin
      case (state_q)
        ST_OP: begin
          if (!op_accept) begin
            state_d = ST_IGN;
          end else if (byte_in == STATUS_READ_CMD) begin
            state_d = ST_SRD;
          end else if (byte_in == STATUS_WRITE_CMD) begin
            state_d = ST_SWR;
          end else if (byte_in == MEM_READ_CMD || byte_in == MEM_WRITE_CMD) begin
            state_d = ST_ADDR;
          end else begin
            state_d = ST_IGN;
          end
        end
        ST_ADDR: begin
          if (addr_last) begin
            state_d = rd_op ? ST_RDATA : ST_WDATA;
          end
        end
        ST_SWR:  state_d = ST_IGN;
        default: state_d = state_q;
      endcase
    end
  end

  // input side samples on the rising edge
  always_ff @(posedge i_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state_q    <= ST_OP;
      bit_cnt_q  <= 3'h0;
      addr_cnt_q <= 2'h0;
      shift_q    <= 8'h00;
      addr_q     <= 24'h00_0000;
    end else if (i_hold_n) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q   <= byte_in;
      state_q   <= state_d;
      if (byte_end && state_q == ST_ADDR) begin
        addr_cnt_q <= addr_cnt_q + 2'h1;
        addr_q     <= rd_first ? addr_full + 24'h00_0001 : addr_full;
      end else if (byte_end && state_q == ST_WDATA) begin
        addr_q <= {addr_q[23:8], addr_q[7:0] + 8'h01};
      end else if (byte_end && state_q == ST_RDATA) begin
        addr_q <= addr_q + 24'h00_0001;
      end
    end
  end

  // frame record, left stable for the core once select rises
  always_ff @(posedge i_sck or negedge i_rstn) begin
    if (!i_rstn) begin
      op_q        <= 8'h00;
      op_ok_q     <= 1'b0;
      wr_any_q    <= 1'b0;
      status_write_cmd_got_q  <= 1'b0;
      status_write_cmd_byte_q <= 8'h00;
    end else if (!i_cs_n && byte_end) begin
      if (state_q == ST_OP) begin
        op_q       <= byte_in;
        op_ok_q    <= op_accept;
        wr_any_q   <= 1'b0;
        status_write_cmd_got_q <= 1'b0;
      end else if (state_q == ST_SWR) begin
        status_write_cmd_got_q  <= 1'b1;
        status_write_cmd_byte_q <= byte_in;
      end else if (mem_we) begin
        wr_any_q <= 1'b1;
      end
    end
  end

  // output side changes on the falling edge; reset by select gives high impedance
  always_ff @(negedge i_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_q    <= 8'h00;
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
    end else if (i_hold_n) begin
      so_oe_q <= sending;
      if (sending && bit_cnt_q == 3'h0) begin
        so_q <= tx_src[7];
        tx_q <= {tx_src[6:0], 1'b0};
      end else if (sending) begin
        so_q <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  sec_sync3 #(.W(8), .RST(STATUS_RST)) u_stat_sync (
    .i_clk   (i_sck),
    .i_rst_n (link_rst_n),
    .i_d     (status_w),
    .o_q     (stat_l)
  );

  sec_mem #(.AW(MEM_AW), .DW(8)) u_mem (
    .i_clk   (i_sck),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (byte_in),
    .i_re    (mem_re),
    .i_raddr (mem_raddr),
    .o_rdata (mem_rdata)
  );

  // ---------------- core domain (i_clk) ----------------
  logic [1:0]          pin_s;
  logic                cs_prev_q;
  logic                busy_q;
  logic                wel_q;
  logic                guard_pin_enable_bit_q;
  logic                ipl_q;
  logic                lip_q;
  logic [1:0]          bp_q;
  logic [WC_CNT_W-1:0] wc_cnt_q;
  logic                o_busy_q;

  wire cs_s      = pin_s[0];
  wire wp_s      = pin_s[1];
  wire cs_rise   = cs_s & ~cs_prev_q;
  wire frame_op  = cs_rise & op_ok_q;
  wire pin_guard = ~wp_s & guard_pin_enable_bit_q;
  wire status_write_cmd_ok   = frame_op & (op_q == STATUS_WRITE_CMD) & status_write_cmd_got_q & wel_q & ~busy_q & ~pin_guard;
  wire memw_ok   = frame_op & (op_q == MEM_WRITE_CMD) & wr_any_q;
  wire start_wc  = status_write_cmd_ok | memw_ok;
  wire wc_end    = busy_q & (wc_cnt_q == WC_CNT_W'(1));
  wire both_id   = status_write_cmd_byte_q[ID_PAGE_SELECT_BIT] & status_write_cmd_byte_q[ID_PAGE_LOCK_BIT];
  wire mem_op    = frame_op & ((op_q == MEM_READ_CMD) | (op_q == MEM_WRITE_CMD));

  assign status_w = {guard_pin_enable_bit_q, ipl_q, 1'b0, lip_q, bp_q, wel_q, busy_q};

  sec_sync3 #(.W(2), .RST(2'h3)) u_pin_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rstn),
    .i_d     ({i_wp_n, i_cs_n}),
    .o_q     (pin_s)
  );

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cs_prev_q <= 1'b1;
      busy_q    <= 1'b0;
      wc_cnt_q  <= '0;
      o_busy_q  <= 1'b0;
    end else begin
      cs_prev_q <= cs_s;
      o_busy_q  <= busy_q;
      if (start_wc) begin
        busy_q   <= 1'b1;
        wc_cnt_q <= WC_CNT_W'(WR_CYCLES);
      end else if (busy_q) begin
        busy_q   <= ~wc_end;
        wc_cnt_q <= wc_cnt_q - WC_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wel_q  <= 1'b0;
      guard_pin_enable_bit_q <= 1'b0;
      ipl_q  <= 1'b0;
      lip_q  <= 1'b0;
      bp_q   <= BP_NONE;
    end else begin
      if (wc_end) begin
        wel_q <= 1'b0;
      end else if (frame_op && op_q == SET_WRITE_LATCH_CMD) begin
        wel_q <= 1'b1;
      end else if (frame_op && op_q == CLEAR_WRITE_LATCH_CMD) begin
        wel_q <= 1'b0;
      end
      if (status_write_cmd_ok) begin
        guard_pin_enable_bit_q <= status_write_cmd_byte_q[GUARD_PIN_ENABLE_BIT];
        bp_q   <= status_write_cmd_byte_q[BLOCK_HI_BIT:BLOCK_LO_BIT];
        if (!both_id) begin
          ipl_q <= status_write_cmd_byte_q[ID_PAGE_SELECT_BIT];
          lip_q <= lip_q | status_write_cmd_byte_q[ID_PAGE_LOCK_BIT];
        end
      end else if (mem_op) begin
        ipl_q <= 1'b0;
      end
    end
  end

  assign o_so    = so_q;
  assign o_so_oe = so_oe_q;
  assign o_busy  = o_busy_q;

  // ---------------- checks ----------------
  chk_wel_set_op: assert property (@(posedge i_clk) disable iff (!i_rstn)
    frame_op && op_q == SET_WRITE_LATCH_CMD && !wc_end |=> wel_q)
    else $error("write latch not set by set opcode");
  chk_wel_clear_op: assert property (@(posedge i_clk) disable iff (!i_rstn)
    frame_op && op_q == CLEAR_WRITE_LATCH_CMD |=> !wel_q)
    else $error("write latch not cleared by clear opcode");
  chk_status_guard: assert property (@(posedge i_clk) disable iff (!i_rstn)
    cs_rise && op_q == STATUS_WRITE_CMD && !wp_s && guard_pin_enable_bit_q |=> $stable(bp_q) && $stable(guard_pin_enable_bit_q))
    else $error("status written while guard pin active");
  chk_write_start: assert property (@(posedge i_clk) disable iff (!i_rstn)
    start_wc |=> busy_q && wc_cnt_q == WC_CNT_W'(WR_CYCLES))
    else $error("write cycle did not start at deselect");
  chk_busy_span: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $rose(busy_q) |-> busy_q [*8])
    else $error("busy dropped early");
  chk_busy_end: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $fell(busy_q) |-> $past(wc_cnt_q) == WC_CNT_W'(1) && !wel_q)
    else $error("write cycle ended at wrong count");
  chk_so_idle: assert property (@(posedge i_clk) disable iff (!i_rstn)
    cs_s && cs_prev_q |-> !o_so_oe)
    else $error("output driven while deselected");
  chk_ipl_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
    mem_op |=> !ipl_q)
    else $error("page select kept after memory access");
  chk_bad_opcode: assert property (@(posedge i_sck) disable iff (!link_rst_n)
    state_q == ST_OP && byte_end && !is_known(byte_in) |=> state_q == ST_IGN)
    else $error("unknown opcode not ignored");
  chk_ign_sticky: assert property (@(posedge i_sck) disable iff (!link_rst_n)
    state_q == ST_IGN |=> state_q == ST_IGN && !op_ok_q || $stable(op_q))
    else $error("ignore state left before deselect");
  chk_id_lock: assert property (@(posedge i_sck) disable iff (!link_rst_n)
    mem_we |-> !(ipl_l && lip_l))
    else $error("locked id page written");
  chk_hold_freeze: assert property (@(posedge i_sck) disable iff (!link_rst_n)
    !i_hold_n |=> $stable(bit_cnt_q) && $stable(state_q))
    else $error("transfer moved during pause");
  cov_wel_set: cover property (@(posedge i_clk) disable iff (!i_rstn)
    frame_op && op_q == SET_WRITE_LATCH_CMD);
  cov_mem_write: cover property (@(posedge i_clk) disable iff (!i_rstn) memw_ok);
  cov_status_write: cover property (@(posedge i_clk) disable iff (!i_rstn) status_write_cmd_ok);
  cov_mem_read: cover property (@(posedge i_sck) disable iff (!link_rst_n) state_q == ST_RDATA);
endmodule

// File: logic/sec_pkg.sv
// shared constants and types of the serial eeprom command interface
package sec_pkg;
  localparam int CLK_MHZ    = 250;
  localparam int WC_TIME_MS = 5;
  localparam int WC_CYCLES  = WC_TIME_MS * CLK_MHZ * 1000;
  localparam int WC_CNT_W   = 21;

  localparam int MEM_AW     = 18;
  localparam int ADDR_BYTES = 3;

  localparam logic [7:0] SET_WRITE_LATCH_CMD   = 8'h06;
  localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD       = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD      = 8'h01;
  localparam logic [7:0] MEM_READ_CMD          = 8'h03;
  localparam logic [7:0] MEM_WRITE_CMD         = 8'h02;

  localparam int BUSY_BIT                 = 0;
  localparam int WRITE_ENABLE_LATCH_BIT   = 1;
  localparam int BLOCK_LO_BIT             = 2;
  localparam int BLOCK_HI_BIT             = 3;
  localparam int ID_PAGE_LOCK_BIT         = 4;
  localparam int ID_PAGE_SELECT_BIT       = 6;
  localparam int GUARD_PIN_ENABLE_BIT     = 7;

  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam logic [1:0] ADDR_LAST  = 2'h2;
  localparam logic [1:0] BP_NONE    = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF    = 2'h2;
  localparam logic [1:0] BP_FULL    = 2'h3;

  typedef enum logic [2:0] {
    ST_OP    = 3'b000,
    ST_ADDR  = 3'b001,
    ST_WDATA = 3'b010,
    ST_RDATA = 3'b011,
    ST_SRD   = 3'b100,
    ST_SWR   = 3'b101,
    ST_IGN   = 3'b110
  } sec_link_st_e;
endpackage

// File: logic/sec_sync3.sv
// three-stage synchroniser; a bit changes once stages two and three agree
`timescale 1ns/1ps
module sec_sync3 #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_q;
  wire  [W-1:0] agree = ~(s2_q ^ s3_q);

  if (W < 1) begin : g_chk
    $error("sec_sync3 needs W of one or more");
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      q_q  <= RST;
    end else begin
      s1_q <= i_d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q  <= (s3_q & agree) | (q_q & ~agree);
    end
  end

  assign o_q = q_q;
endmodule

// File: logic/sec_mem.sv
// byte memory for main array and identification page, registered read
`timescale 1ns/1ps
module sec_mem #(
  parameter int AW = 18,
  parameter int DW = 8
) (
  input  wire logic          i_clk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic          i_re,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1];
  logic [DW-1:0] rdata_q;

  if (AW < 9 || DW < 1) begin : g_chk
    $error("sec_mem needs AW of nine or more and DW of one or more");
  end

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
    if (i_re) begin
      rdata_q <= mem_q[i_raddr];
    end
  end

  assign o_rdata = rdata_q;
endmodule

// File: test/sec_host.sv
// host serial master model: framed transfers in clock modes (0,0) and (1,1), with pause
`timescale 1ns/1ps
module sec_host (
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si,
  output logic      o_hold_n,
  input  wire logic i_so,
  input  wire logic i_so_oe
);
  initial begin
    o_sck    = 1'b0;
    o_cs_n   = 1'b1;
    o_si     = 1'b0;
    o_hold_n = 1'b1;
  end

  // one bit: falling edge with new data, then rising edge where so is taken
  task automatic bit_xfer(input logic b, output logic r, inout logic oe);
    o_sck = 1'b0;
    o_si  = b;
    #6;
    o_sck = 1'b1;
    r     = i_so;
    oe    = oe | i_so_oe;
    #6;
  endtask

  // clock pulses while paused must be ignored by the device
  task automatic pause_mid();
    o_sck = 1'b0;
    #6;
    o_hold_n = 1'b0;
    #6;
    for (int p = 0; p < 3; p++) begin
      o_si  = ~o_si;
      o_sck = 1'b1;
      #6;
      o_sck = 1'b0;
      #6;
    end
    o_hold_n = 1'b1;
    #6;
  endtask

  task automatic frame(input logic [7:0] tx[$], input int nrd, input bit m11, input bit pz,
                       output logic [7:0] rx[$], output logic oe);
    logic [7:0] v;
    logic       r;
    rx = {};
    oe = 1'b0;
    #1.7;
    o_sck = m11;
    #6;
    o_cs_n = 1'b0;
    #6;
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) bit_xfer(tx[i][k], r, oe);
      if (pz && i == 0) pause_mid();
    end
    for (int n = 0; n < nrd; n++) begin
      for (int k = 7; k >= 0; k--) begin
        bit_xfer(~o_si, r, oe);
        v[k] = r;
      end
      rx.push_back(v);
    end
    if (!m11) o_sck = 1'b0;
    #6;
    o_cs_n = 1'b1;
    o_si   = ~o_si;
    #40;
  endtask
endmodule

// File: test/test_sec_top.sv
// self-checking bench of the serial eeprom command interface
`timescale 1ns/1ps
module test_sec_top;
  import sec_pkg::*;
  localparam int         WRC   = 200;
  localparam logic [7:0] BUSY  = 8'h01 << BUSY_BIT;
  localparam logic [7:0] LATCH = 8'h01 << WRITE_ENABLE_LATCH_BIT;
  localparam logic [7:0] LOCK  = 8'h01 << ID_PAGE_LOCK_BIT;
  localparam logic [7:0] SEL   = 8'h01 << ID_PAGE_SELECT_BIT;
  localparam logic [7:0] GUARD = 8'h01 << GUARD_PIN_ENABLE_BIT;
  logic       i_clk;
  logic       i_rstn;
  logic       i_wp_n;
  wire        sck;
  wire        cs_n;
  wire        si;
  wire        hold_n;
  wire        so_w;
  logic       o_so;
  logic       o_so_oe;
  logic       o_busy;
  int         miscompares;
  int         tests_run;
  int         cyc;
  int         run;
  int         last_run;
  logic [7:0] rx[$];
  logic       oe;

  sec_top #(.WR_CYCLES(WRC)) uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
    .i_wp_n(i_wp_n), .i_hold_n(hold_n), .o_so(o_so), .o_so_oe(o_so_oe), .o_busy(o_busy));
  sec_host host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .o_hold_n(hold_n), .i_so(so_w), .i_so_oe(o_so_oe));
  assign so_w = o_so_oe ? o_so : 1'bz;

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // length of the last busy pulse, and the hang limit
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_busy === 1'b1) run <= run + 1;
    else if (run != 0) begin
      last_run <= run;
      run      <= 0;
    end
    if (cyc == 40000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmd(input logic [7:0] tx[$], input int nrd = 0, input bit m11 = 0, input bit pz = 0);
    host.frame(tx, nrd, m11, pz, rx, oe);
  endtask

  task automatic status_read_cmd(input logic [7:0] exp);
    cmd({STATUS_READ_CMD}, 2);
    check("status", exp, rx[0]);
    check("status repeat", exp, rx[1]);
  endtask

  task automatic wait_idle();
    for (int n = 0; n < 16 && o_busy !== 1'b1; n++) @(posedge i_clk);
    for (int n = 0; n < WRC + 20 && o_busy === 1'b1; n++) @(posedge i_clk);
    repeat (2) @(posedge i_clk);
    #1;
  endtask

  task automatic status_write_cmd(input logic [7:0] v);
    cmd({SET_WRITE_LATCH_CMD});
    cmd({STATUS_WRITE_CMD, v});
    wait_idle();
  endtask

  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    cmd({SET_WRITE_LATCH_CMD});
    cmd({MEM_WRITE_CMD, a[23:16], a[15:8], a[7:0], d});
    wait_idle();
  endtask

  task automatic rd(input logic [23:0] a, input int n, input bit pz = 0);
    cmd({MEM_READ_CMD, a[23:16], a[15:8], a[7:0]}, n, 0, pz);
  endtask

  task automatic set_wp(input logic v);
    @(posedge i_clk);
    i_wp_n <= v;
    repeat (6) @(posedge i_clk);
  endtask

  task automatic t_idle();
    #1;
    check("busy pin", 8'h00, {7'h00, o_busy});
    check("so enable", 8'h00, {7'h00, o_so_oe});
    status_read_cmd(STATUS_RST);
  endtask

  task automatic t_latch();
    cmd({SET_WRITE_LATCH_CMD});
    status_read_cmd(LATCH);
    cmd({STATUS_READ_CMD}, 1, 1);
    check("status mode 11", LATCH, rx[0]);
    cmd({CLEAR_WRITE_LATCH_CMD});
    status_read_cmd(8'h00);
  endtask

  task automatic t_unknown();
    cmd({8'h86, 8'h00}, 2);
    check("so enable after unknown", 8'h00, {7'h00, oe});
    status_read_cmd(8'h00);
  endtask

  task automatic t_write_read();
    cmd({SET_WRITE_LATCH_CMD});
    cmd({MEM_WRITE_CMD, 8'h00, 8'h01, 8'h10, 8'ha5, 8'h3c}, 0, 1);
    check("busy pin", 8'h01, {7'h00, o_busy});
    status_read_cmd(LATCH | BUSY);
    wait_idle();
    check("busy length", 8'h00, (last_run >= WRC && last_run <= WRC + 1) ? 8'h00 : 8'h01);
    status_read_cmd(8'h00);
    cmd({MEM_WRITE_CMD, 8'h00, 8'h01, 8'h10, 8'h77});
    repeat (10) @(posedge i_clk);
    #1;
    check("busy without latch", 8'h00, {7'h00, o_busy});
    rd(24'h00_0110, 2, 1);
    check("read byte 0", 8'ha5, rx[0]);
    check("read byte 1", 8'h3c, rx[1]);
    check("so enable", 8'h00, {7'h00, o_so_oe});
  endtask

  task automatic t_protect();
    set_wp(1'b0);
    status_write_cmd(GUARD);
    status_read_cmd(GUARD);
    cmd({SET_WRITE_LATCH_CMD});
    cmd({STATUS_WRITE_CMD, GUARD | 8'h04});
    wait_idle();
    status_read_cmd(GUARD | LATCH);
    set_wp(1'b1);
    cmd({STATUS_WRITE_CMD, 8'h00});
    wait_idle();
    status_read_cmd(8'h00);
  endtask

  // quarter protection: upper quarter refuses data, the rest of the upper half takes it
  task automatic t_block();
    wr(24'h01_8000, 8'h44);
    status_write_cmd(8'h04);
    wr(24'h01_8000, 8'hbb);
    status_read_cmd(8'h04 | LATCH);
    wr(24'h01_0000, 8'h55);
    status_read_cmd(8'h04);
    rd(24'h01_8000, 1);
    check("guarded block byte", 8'h44, rx[0]);
    rd(24'h01_0000, 1);
    check("open block byte", 8'h55, rx[0]);
  endtask

  task automatic t_id_page();
    wr(24'h00_0005, 8'hc3);
    status_write_cmd(SEL);
    status_read_cmd(SEL);
    wr(24'h00_0005, 8'h5a);
    status_read_cmd(8'h00);
    status_write_cmd(SEL);
    rd(24'h00_0005, 1);
    check("id page byte", 8'h5a, rx[0]);
    rd(24'h00_0005, 1);
    check("main byte", 8'hc3, rx[0]);
    status_write_cmd(LOCK);
    status_write_cmd(SEL);
    wr(24'h00_0005, 8'h11);
    status_read_cmd(LOCK | LATCH);
    // the refused write still ended the page selection, so select again before reading back
    status_write_cmd(SEL);
    rd(24'h00_0005, 1);
    check("locked id byte", 8'h5a, rx[0]);
    status_read_cmd(LOCK);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    i_rstn      = 1'b0;
    i_wp_n      = 1'b1;
    miscompares = 0;
    tests_run   = 0;
    cyc         = 0;
    run         = 0;
    last_run    = 0;
    repeat (5) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (10) @(posedge i_clk);
    t_idle();
    t_latch();
    t_unknown();
    t_write_read();
    t_protect();
    t_block();
    t_id_page();
    conclude();
  end
endmodule
